// ===== rle_pkg.sv
// constants, tables and state types of the excitation and synthesis datapath
package rle_pkg;

  // ----------------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------------
  localparam int SUB_LEN = 40;
  localparam int HIST_LEN = 120;
  localparam int FRAME_LEN = 160;
  localparam int NUM_PULSES = 13;
  localparam int NUM_TAPS = 11;
  localparam int NUM_STAGES = 8;
  localparam logic [6:0] LAG_MIN = 7'h28;
  localparam logic [6:0] LAG_MAX = 7'h78;
  localparam int INTERP_END_0 = 12;
  localparam int INTERP_END_1 = 26;
  localparam int INTERP_END_2 = 39;

  // ----------------------------------------------------------------------
  // arithmetic constants
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] WORD_MAX = 16'sh7fff;
  localparam logic signed [15:0] WORD_MIN = 16'sh8000;
  localparam logic signed [33:0] ROUND_Q15 = 34'sh0000_4000;
  localparam logic signed [15:0] DEEMPH_COEF = 16'sh6e14;
  localparam logic signed [15:0] RP_KNEE_0 = 16'sh2b33;
  localparam logic signed [15:0] RP_KNEE_1 = 16'sh4e66;
  localparam logic signed [15:0] RP_OFFSET = 16'sh6600;
  localparam logic [15:0] TRUNC_MASK = 16'hfff8;

  // ----------------------------------------------------------------------
  // tables
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] GAIN_TABLE [4] = '{16'sh0ccd, 16'sh2ccd, 16'sh5333, 16'sh7fff};
  localparam logic signed [15:0] WEIGHT_TAPS [11] = '{16'shff7a, 16'shfe8a, 16'sh0000,
    16'sh0806, 16'sh166d, 16'sh2000, 16'sh166d, 16'sh0806, 16'sh0000, 16'shfe8a, 16'shff7a};
  localparam logic signed [15:0] INV_MANT_TABLE [8] = '{16'sh71c8, 16'sh6667, 16'sh5d18,
    16'sh5556, 16'sh4ec5, 16'sh4925, 16'sh4444, 16'sh4000};
  localparam logic signed [15:0] MANT_TABLE [8] = '{16'sh47ff, 16'sh4fff, 16'sh57ff,
    16'sh5fff, 16'sh67ff, 16'sh6fff, 16'sh77ff, 16'sh7fff};
  localparam logic signed [15:0] LAR_MIN_TABLE [8] = '{16'shffe0, 16'shffe0, 16'shfff0,
    16'shfff0, 16'shfff8, 16'shfff8, 16'shfffc, 16'shfffc};
  localparam logic signed [15:0] LAR_OFS_TABLE [8] = '{16'sh0000, 16'sh0000, 16'sh0800,
    16'shf600, 16'sh005e, 16'shf900, 16'shfeab, 16'shfb88};
  localparam logic signed [15:0] LAR_INV_TABLE [8] = '{16'sh3333, 16'sh3333, 16'sh3333,
    16'sh3333, 16'sh4b17, 16'sh4444, 16'sh7ade, 16'sh740c};

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ENC_IDLE, ENC_LOAD, ENC_WEIGHT, ENC_QUANT, ENC_UPDATE
  } rle_enc_st_t;

  typedef enum logic [2:0] {
    DEC_IDLE, DEC_RPE, DEC_LTP, DEC_SHIFT, DEC_SYNTH
  } rle_dec_st_t;

endpackage : rle_pkg

// ===== rle_core.sv
// excitation encoder loop and speech decoder datapath
// Contract
// - estimate is rounded gain times lagged history
// - weighting: zero padded 11-tap convolution, x4
// - pulses are every third weighted sample
// - block maximum is largest absolute pulse
// - exponent by halvings, coded maximum formed
// - exponent and mantissa split from coded maximum
// - pulse code from scaled inverse-mantissa product
// - inverse quantize pulse code with rounding
// - clear residual then place pulses on grid
// - history shifts 40, newest is residual+estimate
// - per sub-segment pulses and ltp, per-frame synthesis
// - decoder lag used only inside 40..120, else previous; encoder lag clamped to 40..120
// - decoder residual plus gain-scaled history, then shift
// - sub-segment n lands at offset 40n
// - eight-stage lattice with persistent zeroed state
// - interpolated coefficient sets over four ranges
// - reflection coefficients decoded once per frame
// - de-emphasis with 28180 feedback, saturating
// - output doubled with saturation
// - three low output bits forced zero
// - decoder reuses split, inverse quantization, grid
// - gain table 3277, 11469, 21299, 32767
// - symmetric weighting taps
// - inverse-mantissa and mantissa tables
module rle_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enc_start,
  input wire logic [1:0] enc_ltp_gain_code,
  input wire logic [6:0] enc_lag,
  input wire logic [1:0] enc_grid_position_code,
  input wire logic enc_d_valid,
  input wire logic [15:0] enc_d_sample,
  output logic enc_busy,
  output logic enc_d_ready,
  output logic enc_done,
  output logic [5:0] enc_coded_max,
  output logic [38:0] enc_pulse_codes,
  input wire logic dec_start,
  input wire logic [1:0] dec_ltp_gain_code,
  input wire logic [6:0] dec_lag,
  input wire logic [1:0] dec_grid_position_code,
  input wire logic [5:0] dec_coded_max,
  input wire logic [38:0] dec_pulse_codes,
  input wire logic [47:0] dec_lar_codes,
  output logic dec_busy,
  output logic dec_sample_valid,
  output logic [15:0] dec_sample,
  output logic dec_frame_done
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    rle_pkg::rle_enc_st_t enc_st;
    rle_pkg::rle_dec_st_t dec_st;
    logic [7:0] enc_k;
    logic [7:0] dec_k;
    logic [1:0] sub;
    logic [1:0] enc_gain;
    logic [6:0] enc_lag;
    logic [1:0] enc_grid;
    logic [119:0][15:0] residual_history;
    logic [39:0][15:0] e, dpp, x, rebuilt_long_term_residual;
    logic [1:0] dec_gain;
    logic [6:0] lag_in_use;
    logic [1:0] dec_grid;
    logic [5:0] dec_xmaxc;
    logic [38:0] dec_codes;
    logic [47:0] lar_codes;
    logic [119:0][15:0] dec_history;
    logic [39:0][15:0] erp;
    logic [159:0][15:0] frame;
    logic [7:0][15:0] larpp_prev;
    logic [8:0][15:0] v;
    logic [15:0] msr;
    logic enc_busy;
    logic enc_d_ready;
    logic enc_done;
    logic [5:0] enc_coded_max;
    logic [38:0] enc_pulse_codes;
    logic dec_busy;
    logic dec_sample_valid;
    logic [15:0] dec_sample;
    logic dec_frame_done;
  } rle_state_t;

  rle_state_t q;
  rle_state_t d;

  // ----------------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------------
  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'(rle_pkg::WORD_MAX)) return rle_pkg::WORD_MAX;
    if (v < 34'(rle_pkg::WORD_MIN)) return rle_pkg::WORD_MIN;
    return v[15:0];
  endfunction : sat16

  function automatic logic signed [15:0] add16(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    return sat16(34'(a) + 34'(b));
  endfunction : add16

  function automatic logic signed [15:0] sub16(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    return sat16(34'(a) - 34'(b));
  endfunction : sub16

  function automatic logic signed [15:0] abs16(input logic signed [15:0] a);
    return (a < 0) ? sub16(16'sh0000, a) : a;
  endfunction : abs16

  function automatic logic signed [15:0] mult_r(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return sat16((34'(p) + rle_pkg::ROUND_Q15) >>> 15);
  endfunction : mult_r

  function automatic logic signed [15:0] mult_t(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return sat16(34'(p) >>> 15);
  endfunction : mult_t

  function automatic logic signed [31:0] sat32(input logic signed [39:0] v);
    if (v > 40'sh00_7fff_ffff) return 32'sh7fff_ffff;
    if (v < -40'sh00_8000_0000) return 32'sh8000_0000;
    return v[31:0];
  endfunction : sat32

  // weighted sample k over the zero padded residual
  function automatic logic signed [15:0] weigh(input logic [39:0][15:0] e, input int k);
    logic signed [39:0] acc;
    logic signed [31:0] l;
    int j;
    acc = '0;
    for (int i = 0; i < rle_pkg::NUM_TAPS; i++) begin
      j = k + i - 5;
      if (j >= 0 && j < rle_pkg::SUB_LEN) begin
        acc = acc + 40'($signed(e[j]) * rle_pkg::WEIGHT_TAPS[i]) * 40'sd2;
      end
    end
    l = sat32(40'(sat32(acc)) * 40'sd2);
    l = sat32(40'(l) * 40'sd2);
    return l[31:16];
  endfunction : weigh

  function automatic logic [3:0] exp_of(input logic [15:0] xmax);
    logic [15:0] t;
    logic stop;
    logic [3:0] e;
    t = xmax >> 9;
    stop = 1'b0;
    e = '0;
    for (int i = 0; i < 6; i++) begin
      if (t == 16'h0000) stop = 1'b1;
      t = t >> 1;
      if (!stop) e = e + 4'h1;
    end
    return e;
  endfunction : exp_of

  // returns {exponent, mantissa}
  function automatic logic [6:0] split(input logic [5:0] xmaxc);
    logic [3:0] e;
    e = (xmaxc > 6'h0f) ? 4'((xmaxc >> 3) - 6'h01) : 4'h0;
    return {e, 3'(xmaxc - {e[2:0], 3'b000})};
  endfunction : split

  function automatic logic signed [15:0] inv_q(input logic [2:0] code, input logic [3:0] ex,
                                               input logic [2:0] mant);
    logic signed [15:0] t;
    logic signed [15:0] rnd;
    logic [3:0] sh;
    sh = 4'h6 - ex;
    rnd = (sh == 4'h0) ? 16'sh0000 : 16'(16'sh0001 <<< (sh - 4'h1));
    t = $signed({12'h000, code, 1'b0}) - 16'sh0007;
    t = t <<< 12;
    t = mult_r(rle_pkg::MANT_TABLE[mant], t);
    t = add16(t, rnd);
    return t >>> sh;
  endfunction : inv_q

  function automatic logic signed [15:0] lar_dec(input logic [5:0] code, input int i);
    logic signed [15:0] t;
    t = add16($signed({10'h000, code}), rle_pkg::LAR_MIN_TABLE[i]) <<< 10;
    t = sub16(t, rle_pkg::LAR_OFS_TABLE[i] <<< 1);
    t = mult_r(rle_pkg::LAR_INV_TABLE[i], t);
    return add16(t, t);
  endfunction : lar_dec

  function automatic logic signed [15:0] lar_to_rp(input logic signed [15:0] larp);
    logic signed [15:0] t;
    t = abs16(larp);
    if (t < rle_pkg::RP_KNEE_0) t = t <<< 1;
    else if (t < rle_pkg::RP_KNEE_1) t = add16(t, rle_pkg::RP_KNEE_0);
    else t = add16(t >>> 2, rle_pkg::RP_OFFSET);
    return (larp < 0) ? sub16(16'sh0000, t) : t;
  endfunction : lar_to_rp

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic [15:0] xmax;
  logic [3:0] enc_exp;
  logic [5:0] xmaxc;
  logic [6:0] enc_em;
  logic [6:0] dec_em;
  logic [6:0] enc_lag_c;
  logic [2:0] code;
  logic signed [15:0] t16;
  logic signed [15:0] est;
  logic signed [15:0] larp;
  logic signed [15:0] cur;
  logic signed [15:0] prv;
  logic signed [15:0] sri;
  logic signed [15:0] rrp [8];
  int pos;

  always_comb begin
    d = q;
    d.enc_done = 1'b0;
    d.dec_sample_valid = 1'b0;
    d.dec_frame_done = 1'b0;
    xmax = '0;
    code = '0;
    t16 = '0;
    est = '0;
    larp = '0;
    cur = '0;
    prv = '0;
    sri = '0;
    pos = 0;
    for (int i = 0; i < rle_pkg::NUM_STAGES; i++) rrp[i] = '0;
    for (int i = 0; i < rle_pkg::NUM_PULSES; i++) begin
      t16 = abs16(q.x[int'(q.enc_grid) + 3 * i]);
      if (t16 > $signed(xmax)) xmax = t16;
    end
    enc_exp = exp_of(xmax);
    xmaxc = 6'((xmax >> (enc_exp + 4'h5)) + {9'h000, enc_exp, 3'b000});
    enc_em = split(xmaxc);
    dec_em = split(q.dec_xmaxc);
    enc_lag_c = (q.enc_lag < rle_pkg::LAG_MIN) ? rle_pkg::LAG_MIN :
                (q.enc_lag > rle_pkg::LAG_MAX) ? rle_pkg::LAG_MAX : q.enc_lag;

    // ----------------------------------------------------------------------
    // encoder loop
    // ----------------------------------------------------------------------
    unique case (q.enc_st)
      rle_pkg::ENC_IDLE: begin
        if (enc_start) begin
          d.enc_gain = enc_ltp_gain_code;
          d.enc_lag = enc_lag;
          d.enc_grid = enc_grid_position_code;
          d.enc_k = '0;
          d.rebuilt_long_term_residual = '0;
          d.enc_st = rle_pkg::ENC_LOAD;
        end
      end
      rle_pkg::ENC_LOAD: begin
        if (enc_d_valid) begin
          pos = int'(q.enc_k) + rle_pkg::HIST_LEN - int'(enc_lag_c);
          est = mult_r(rle_pkg::GAIN_TABLE[q.enc_gain], q.residual_history[pos]);
          d.dpp[q.enc_k] = est;
          d.e[q.enc_k] = sub16(enc_d_sample, est);
          d.enc_k = q.enc_k + 8'h01;
          if (q.enc_k == 8'(rle_pkg::SUB_LEN - 1)) begin
            d.enc_k = '0;
            d.enc_st = rle_pkg::ENC_WEIGHT;
          end
        end
      end
      rle_pkg::ENC_WEIGHT: begin
        d.x[q.enc_k] = weigh(q.e, int'(q.enc_k));
        d.enc_k = q.enc_k + 8'h01;
        if (q.enc_k == 8'(rle_pkg::SUB_LEN - 1)) begin
          d.enc_k = '0;
          d.enc_st = rle_pkg::ENC_QUANT;
        end
      end
      rle_pkg::ENC_QUANT: begin
        pos = int'(q.enc_grid) + 3 * int'(q.enc_k);
        t16 = $signed(q.x[pos]) <<< (4'h6 - enc_em[6:3]);
        t16 = mult_t(t16, rle_pkg::INV_MANT_TABLE[enc_em[2:0]]);
        code = 3'((t16 >>> 12) + 16'sh0004);
        d.rebuilt_long_term_residual[pos] = inv_q(code, enc_em[6:3], enc_em[2:0]);
        d.enc_pulse_codes[3 * int'(q.enc_k) +: 3] = code;
        d.enc_k = q.enc_k + 8'h01;
        if (q.enc_k == 8'(rle_pkg::NUM_PULSES - 1)) begin
          d.enc_st = rle_pkg::ENC_UPDATE;
        end
      end
      rle_pkg::ENC_UPDATE: begin
        for (int j = 0; j < 80; j++) d.residual_history[j] = q.residual_history[j + 40];
        for (int j = 0; j < rle_pkg::SUB_LEN; j++) begin
          d.residual_history[80 + j] = add16(q.rebuilt_long_term_residual[j], q.dpp[j]);
        end
        d.enc_coded_max = xmaxc;
        d.enc_done = 1'b1;
        d.enc_st = rle_pkg::ENC_IDLE;
      end
    endcase

    // ----------------------------------------------------------------------
    // decoder
    // ----------------------------------------------------------------------
    unique case (q.dec_st)
      rle_pkg::DEC_IDLE: begin
        if (dec_start) begin
          d.dec_gain = dec_ltp_gain_code;
          d.dec_grid = dec_grid_position_code;
          d.dec_xmaxc = dec_coded_max;
          d.dec_codes = dec_pulse_codes;
          if (dec_lag >= rle_pkg::LAG_MIN && dec_lag <= rle_pkg::LAG_MAX) begin
            d.lag_in_use = dec_lag;
          end
          if (q.sub == 2'h0) d.lar_codes = dec_lar_codes;
          d.erp = '0;
          d.dec_k = '0;
          d.dec_st = rle_pkg::DEC_RPE;
        end
      end
      rle_pkg::DEC_RPE: begin
        pos = int'(q.dec_grid) + 3 * int'(q.dec_k);
        code = q.dec_codes[3 * int'(q.dec_k) +: 3];
        d.erp[pos] = inv_q(code, dec_em[6:3], dec_em[2:0]);
        d.dec_k = q.dec_k + 8'h01;
        if (q.dec_k == 8'(rle_pkg::NUM_PULSES - 1)) begin
          d.dec_k = '0;
          d.dec_st = rle_pkg::DEC_LTP;
        end
      end
      rle_pkg::DEC_LTP: begin
        pos = int'(q.dec_k) + rle_pkg::HIST_LEN - int'(q.lag_in_use);
        est = mult_r(rle_pkg::GAIN_TABLE[q.dec_gain], q.dec_history[pos]);
        d.frame[rle_pkg::SUB_LEN * int'(q.sub) + int'(q.dec_k)] =
          add16(q.erp[q.dec_k], est);
        d.dec_k = q.dec_k + 8'h01;
        if (q.dec_k == 8'(rle_pkg::SUB_LEN - 1)) begin
          d.dec_st = rle_pkg::DEC_SHIFT;
        end
      end
      rle_pkg::DEC_SHIFT: begin
        for (int j = 0; j < 80; j++) d.dec_history[j] = q.dec_history[j + 40];
        for (int j = 0; j < rle_pkg::SUB_LEN; j++) begin
          d.dec_history[80 + j] = q.frame[rle_pkg::SUB_LEN * int'(q.sub) + j];
        end
        d.sub = q.sub + 2'h1;
        d.dec_k = '0;
        d.dec_st = (q.sub == 2'h3) ? rle_pkg::DEC_SYNTH : rle_pkg::DEC_IDLE;
      end
      rle_pkg::DEC_SYNTH: begin
        for (int i = 0; i < rle_pkg::NUM_STAGES; i++) begin
          cur = lar_dec(q.lar_codes[6 * i +: 6], i);
          prv = q.larpp_prev[i];
          if (int'(q.dec_k) <= rle_pkg::INTERP_END_0) begin
            larp = add16(add16(prv >>> 2, cur >>> 2), prv >>> 1);
          end else if (int'(q.dec_k) <= rle_pkg::INTERP_END_1) begin
            larp = add16(prv >>> 1, cur >>> 1);
          end else if (int'(q.dec_k) <= rle_pkg::INTERP_END_2) begin
            larp = add16(add16(prv >>> 2, cur >>> 2), cur >>> 1);
          end else begin
            larp = cur;
          end
          rrp[i] = lar_to_rp(larp);
          if (q.dec_k == 8'(rle_pkg::FRAME_LEN - 1)) d.larpp_prev[i] = cur;
        end
        sri = q.frame[q.dec_k];
        for (int i = 1; i <= rle_pkg::NUM_STAGES; i++) begin
          sri = sub16(sri, mult_r(rrp[8 - i], q.v[8 - i]));
          d.v[9 - i] = add16(q.v[8 - i], mult_r(rrp[8 - i], sri));
        end
        d.v[0] = sri;
        t16 = add16(sri, mult_r(q.msr, rle_pkg::DEEMPH_COEF));
        d.msr = t16;
        d.dec_sample = add16(t16, t16) & rle_pkg::TRUNC_MASK;
        d.dec_sample_valid = 1'b1;
        d.dec_k = q.dec_k + 8'h01;
        if (q.dec_k == 8'(rle_pkg::FRAME_LEN - 1)) begin
          d.dec_frame_done = 1'b1;
          d.dec_st = rle_pkg::DEC_IDLE;
        end
      end
    endcase

    d.enc_busy = d.enc_st != rle_pkg::ENC_IDLE;
    d.enc_d_ready = d.enc_st == rle_pkg::ENC_LOAD;
    d.dec_busy = d.dec_st != rle_pkg::DEC_IDLE;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.lag_in_use <= rle_pkg::LAG_MIN;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign enc_busy = q.enc_busy;
  assign enc_d_ready = q.enc_d_ready;
  assign enc_done = q.enc_done;
  assign enc_coded_max = q.enc_coded_max;
  assign enc_pulse_codes = q.enc_pulse_codes;
  assign dec_busy = q.dec_busy;
  assign dec_sample_valid = q.dec_sample_valid;
  assign dec_sample = q.dec_sample;
  assign dec_frame_done = q.dec_frame_done;

endmodule : rle_core

// ===== rle_checker.sv
// concurrent checks on the ports of the excitation and synthesis core
module rle_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enc_start,
  input wire logic enc_busy,
  input wire logic enc_d_ready,
  input wire logic enc_done,
  input wire logic [5:0] enc_coded_max,
  input wire logic dec_start,
  input wire logic dec_busy,
  input wire logic dec_sample_valid,
  input wire logic [15:0] dec_sample,
  input wire logic dec_frame_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // output samples seen so far in the current frame
  // ------------------------------------------------
  logic [7:0] vcnt_q;
  logic [7:0] vcnt_d;
  always_comb begin
    vcnt_d = vcnt_q;
    if (dec_frame_done) begin
      vcnt_d = 8'h00;
    end else if (dec_sample_valid) begin
      vcnt_d = vcnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vcnt_q <= 8'h00;
    end else begin
      vcnt_q <= vcnt_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_enc_latency: assert property (enc_start && !enc_busy |-> ##95 enc_done)
    else $error("encoder sub-segment late or early");
  a_residual_span: assert property (
    enc_start && !enc_busy |=> enc_d_ready ##40 !enc_d_ready)
    else $error("residual intake not 40 cycles");
  a_done_idle: assert property (enc_done |-> !enc_busy && $past(enc_busy))
    else $error("done without a finished run");
  a_max_held: assert property (!enc_done |-> $stable(enc_coded_max))
    else $error("coded maximum moved outside done");
  a_low_bits: assert property (dec_sample_valid |-> dec_sample[2:0] == 3'h0)
    else $error("output low bits not zero");
  a_frame_len: assert property (dec_frame_done |-> dec_sample_valid && vcnt_q == 8'h9f)
    else $error("frame end not on sample 160");
  a_stream_run: assert property ($rose(dec_sample_valid) |-> dec_sample_valid[*8])
    else $error("output stream broken");
  a_frame_release: assert property (dec_frame_done |=> !dec_busy)
    else $error("decoder busy after frame end");
  a_sub_quiet: assert property (
    dec_start && !dec_busy |=> (dec_busy && !dec_sample_valid)[*8])
    else $error("decoder output before pulse decode");
  c_enc_done: cover property (enc_done);
  c_frame_done: cover property (dec_frame_done);
  c_dec_start: cover property (dec_start && !dec_busy);
endmodule : rle_checker

bind rle_core rle_checker i_chk (.clk, .rst_b, .enc_start, .enc_busy, .enc_d_ready, .enc_done,
  .enc_coded_max, .dec_start, .dec_busy, .dec_sample_valid, .dec_sample, .dec_frame_done);

// ===== rle_chan_model.sv
// far-side model: residual sample feeder and output sample collector
module rle_chan_model (
  input wire logic clk,
  input wire logic feed,
  input wire logic arm,
  input wire logic enc_d_ready,
  output logic enc_d_valid,
  output logic [15:0] enc_d_sample,
  input wire logic dec_sample_valid,
  input wire logic [15:0] dec_sample,
  input wire logic dec_frame_done,
  output int got,
  output int done_at,
  output logic [15:0] pcm [160]
);
  timeunit 1ns;
  timeprecision 1ps;
  int sent = 0;
  int nxt;
  initial begin
    enc_d_valid = 1'b0;
    enc_d_sample = 16'h0000;
    got = 0;
    done_at = -1;
  end
  // silent residual, held until taken; idle data toggles every cycle
  always @(posedge clk) begin
    nxt = (feed && enc_d_valid && enc_d_ready) ? sent + 1 : (feed ? sent : 0);
    sent <= nxt;
    enc_d_valid <= feed && nxt < 40;
    enc_d_sample <= (feed && nxt < 40) ? 16'h0000 : ~enc_d_sample;
    if (!arm) begin
      got <= 0;
      done_at <= -1;
    end else if (dec_sample_valid && got < 160) begin
      pcm[got] <= dec_sample;
      got <= got + 1;
      if (dec_frame_done) begin
        done_at <= got;
      end
    end
  end
endmodule : rle_chan_model

// ===== tb_rpe_ltp_excitation_synthesis.sv
// self-checking bench for the excitation and synthesis core
module tb_rpe_ltp_excitation_synthesis;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic enc_start = 1'b0;
  logic [1:0] enc_ltp_gain_code = 2'h3;
  logic [6:0] enc_lag = 7'h28;
  logic [1:0] enc_grid_position_code = 2'h2;
  logic dec_start = 1'b0;
  logic [1:0] dec_ltp_gain_code = 2'h3;
  logic [6:0] dec_lag = 7'h28;
  logic [1:0] dec_grid_position_code = 2'h0;
  logic [5:0] dec_coded_max = 6'h00;
  logic [38:0] dec_pulse_codes = {13{3'h4}};
  logic [47:0] dec_lar_codes = {8{6'h20}};
  logic feed = 1'b0;
  logic arm = 1'b0;
  logic enc_d_valid, enc_busy, enc_d_ready, enc_done, dec_busy, dec_sample_valid, dec_frame_done;
  logic [15:0] enc_d_sample;
  logic [5:0] enc_coded_max;
  logic [38:0] enc_pulse_codes;
  logic [15:0] dec_sample;
  logic [15:0] pcm [160];
  int got, done_at;
  int error_cnt = 0;
  int comparisons = 0;
  rle_core i_dut (.clk, .rst_b, .enc_start, .enc_ltp_gain_code, .enc_lag, .enc_grid_position_code,
    .enc_d_valid, .enc_d_sample, .enc_busy, .enc_d_ready, .enc_done, .enc_coded_max,
    .enc_pulse_codes, .dec_start, .dec_ltp_gain_code, .dec_lag, .dec_grid_position_code,
    .dec_coded_max, .dec_pulse_codes, .dec_lar_codes, .dec_busy, .dec_sample_valid, .dec_sample,
    .dec_frame_done);
  rle_chan_model i_model (.clk, .feed, .arm, .enc_d_ready, .enc_d_valid, .enc_d_sample,
    .dec_sample_valid, .dec_sample, .dec_frame_done, .got, .done_at, .pcm);
  always #10 clk = ~clk;
  task automatic chk(input logic [38:0] seen, input logic [38:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic too_long();
    error_cnt++;
    $display("BAD t=%0t wait ran out", $time);
    stop_test();
  endtask : too_long
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
  endtask : do_reset
  // outputs quiet after reset
  task automatic t_reset();
    @(negedge clk);
    chk(39'({enc_busy, enc_d_ready, enc_done, dec_busy, dec_sample_valid}), 39'h0);
    chk(39'({enc_coded_max, dec_sample}), 39'h0);
    chk(enc_pulse_codes, 39'h0);
  endtask : t_reset
  task automatic run_enc(input logic [5:0] max_exp, input logic [38:0] codes_exp);
    int n;
    @(negedge clk);
    enc_start = 1'b1;
    feed = 1'b1;
    @(negedge clk);
    enc_start = 1'b0;
    n = 0;
    while (enc_done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) too_long();
    feed = 1'b0;
    chk(39'(enc_coded_max), 39'(max_exp));
    chk(enc_pulse_codes, codes_exp);
  endtask : run_enc
  // silent input, then the same input against the rebuilt history
  task automatic t_enc();
    run_enc(6'h00, {13{3'h4}});
    run_enc(6'h01, {13{3'h3}});
  endtask : t_enc
  task automatic run_frame(input logic [6:0] lag_a, input logic [6:0] lag_b);
    int s;
    int n;
    arm = 1'b0;
    @(negedge clk);
    arm = 1'b1;
    for (s = 0; s < 4; s++) begin
      dec_lag = (s == 0) ? lag_a : lag_b;
      dec_start = 1'b1;
      @(negedge clk);
      dec_start = 1'b0;
      n = 0;
      while (dec_busy !== 1'b0 && n < 300) begin
        @(negedge clk);
        n++;
      end
      if (n == 300) too_long();
    end
    // collector takes the last sample one edge after busy drops
    @(negedge clk);
    chk(39'(got), 39'd160);
    chk(39'(done_at), 39'd159);
    for (n = 0; n < 160; n++) begin
      chk(39'({$isunknown(pcm[n]), pcm[n][2:0]}), 39'h0);
    end
  endtask : run_frame
  // out-of-range lags fall back to the lag in use; reset restores state
  task automatic t_lag();
    logic [6:0] la [5] = '{7'h28, 7'h7f, 7'h27, 7'h78, 7'h78};
    logic [6:0] lb [5] = '{7'h28, 7'h7f, 7'h27, 7'h78, 7'h79};
    logic [15:0] ref_pcm [160];
    int i;
    int k;
    for (i = 0; i < 5; i++) begin
      dec_grid_position_code = (i < 3) ? 2'h0 : 2'h3;
      dec_ltp_gain_code = (i < 3) ? 2'h3 : 2'h1;
      dec_coded_max = (i < 3) ? 6'h00 : 6'h2a;
      dec_pulse_codes = (i < 3) ? {13{3'h4}} : {13{3'h1}};
      dec_lar_codes = (i < 3) ? {8{6'h20}} : {8{6'h15}};
      do_reset();
      run_frame(la[i], lb[i]);
      if (i == 0 || i == 3) begin
        ref_pcm = pcm;
      end else begin
        for (k = 0; k < 160; k++) begin
          chk(39'(pcm[k]), 39'(ref_pcm[k]));
        end
      end
    end
  endtask : t_lag
  initial begin
    do_reset();
    t_reset();
    t_enc();
    t_lag();
    stop_test();
  end
endmodule : tb_rpe_ltp_excitation_synthesis
